// ### hdl/aircon_pkg.sv
/*
 file holds shared constants and types of the housekeeping block.
 assumes a 10 MHz clock and a one-second tick derived from it.
*/
package aircon_pkg;
  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] CMD_OFS  = 8'h00; // command pulses
  localparam logic [7:0] CTRL_OFS = 8'h04; // mode and condition bits
  localparam logic [7:0] OFFT_OFS = 8'h08; // delay-off seconds
  localparam logic [7:0] STAT_OFS = 8'h0C; // block state
  localparam logic [7:0] ABN_OFS  = 8'h10; // abnormality code
  // command bit positions
  localparam int C_ON     = 0; // unit on
  localparam int C_OFF    = 1; // unit off by on/off button
  localparam int C_ION    = 2; // ionizer button
  localparam int C_DEC5   = 3; // timer decrement held 5s
  localparam int C_RESUME = 4; // supply back after loss in run
  localparam int C_FOFF   = 5; // off by forced operation
  localparam int C_ANY    = 6; // any other remote button
  // control bit positions
  localparam int K_HOT    = 2; // hot start
  localparam int K_DEICE  = 3;
  localparam int K_JUDGE  = 4; // operating-mode judgment
  localparam int K_SAMPLE = 5; // delay-on sampling
  localparam int K_ABN    = 6; // other abnormal condition
  localparam int K_ONT    = 7; // on timer set
  localparam int K_OFFT   = 8; // off timer set
  localparam int K_BEEPSEL = 9; // 16-21s hold toggles beep
  localparam logic [9:0] CTRL_RST = 10'h000;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int SEC_CYC       = CLK_HZ; // one second
  localparam logic [4:0] HOLD_COOL = 5'd5;
  localparam logic [4:0] HOLD_HEAT = 5'd8;
  localparam logic [4:0] HOLD_CODE = 5'd11;
  localparam logic [4:0] HOLD_SEL  = 5'd16;
  localparam logic [4:0] HOLD_MAX  = 5'd21;
  localparam logic [7:0] RST_MIN_S  = 8'd178; // 2 min 58 s
  localparam logic [7:0] RST_STEP_S = 8'd6;   // nine steps to 3 min 52 s
  localparam logic [3:0] RST_PATS   = 4'd10;
  localparam logic [10:0] ION_ON_S  = 11'd10;
  localparam logic [10:0] ION_OFF_S = 11'd1800; // 30 min
  localparam logic [4:0] ION_CYC_MAX = 5'd24;
  localparam logic [1:0] BRK_S     = 2'd2;
  localparam logic [7:0] BRK_CODE  = 8'h26; // breakdown abnormality code
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    M_HEAT = 2'b00, M_COOL = 2'b01, M_DRY = 2'b10, M_AUTO = 2'b11
  } mode_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_HOLD = 2'b01, S_CODE = 2'b10, S_HEATSB = 2'b11
  } sw_e;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_s;
endpackage

// ### hdl/aircon_house.sv
/*
 file holds the housekeeping control: delay-off, auto restart,
 auto switch decode, indicators and ionizer sequencing.
 assumes a plain register port on the same clock, and raw panel
 switch and ionizer feedback pins from outside the clock domain.
*/
// Overview of operation
// - stop unit when delay-off time reached
// - restart compressor after one of ten delays
// - no auto restart with on/off timer set
// - blink run LED during special phases
// - blink schedule LED on abnormality
// - hold 0-5s starts auto mode
// - hold 5-8s forces cooling
// - hold 8-11s heat standby, decrement starts
// - hold 11-16s plus decrement changes code
// - hold 16-21s toggles detection or beep
// - ionizer button in standby: fan, ion
// - ionizer button while running: ion, LEDs
// - ionizer stops on off, timer, error
// - ionizer state not kept across off
// - low feedback: 10s on, 30min off, 24
// - feedback recovery clears cycle count
// - error state: ion off, LED blink, beep
// - error left only by off or reset
// - breakdown on high feedback 2s off
// - breakdown stops unit, code, schedule blink
// - breakdown clears when feedback low again
`timescale 1ns/1ps
`default_nettype none
module aircon_house
  import aircon_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYC // shorten in simulation
) (
  // clock and reset
  input  wire logic               MCLK_I,
  input  wire logic               SYS_RST_I,
  // register port
  input  wire aircon_pkg::bus_s   BUS_I,
  output logic [31:0]             RDATA_O,
  // pins from outside
  input  wire logic               AUTO_SW_I,
  input  wire logic               ION_FB_I,
  // loads and indicators
  output logic                    FAN_O,
  output logic                    ION_O,
  output logic                    COMP_EN_O,
  output logic                    LED_RUN_O,
  output logic                    LED_SCHED_O,
  output logic                    LED_ION_O,
  output logic                    BEEP_O
);
  import aircon_pkg::*;

  // ************************************************************
  // time base and input synchronisers
  // ************************************************************
  logic [31:0] pre_q;       // cycle prescaler
  logic        tick;        // one-second strobe
  logic        blink_q;     // blink phase, toggles every second
  logic [1:0]  sw_s_q;      // switch synchroniser
  logic [1:0]  fb_s_q;      // feedback synchroniser
  logic        sw, fb;
  assign tick = (pre_q == 32'(SEC_CYCLES - 1));
  assign sw = sw_s_q[1];
  assign fb = fb_s_q[1];

  // prescaler and blink phase
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      pre_q   <= 32'h0;
      blink_q <= 1'b0;
    end else begin
      pre_q <= tick ? 32'h0 : pre_q + 32'h1;
      if (tick) blink_q <= ~blink_q;
    end
  end

  // two flops before anything reads a pin
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sw_s_q <= 2'b00;
      fb_s_q <= 2'b00;
    end else begin
      sw_s_q <= {sw_s_q[0], AUTO_SW_I};
      fb_s_q <= {fb_s_q[0], ION_FB_I};
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  logic [6:0]  cmd;      // command pulses this cycle
  logic [9:0]  ctrl_q;   // control register
  logic [17:0] offt_q;   // delay-off seconds left
  logic        wr_cmd;
  assign wr_cmd = BUS_I.wr && (BUS_I.addr == CMD_OFS);
  assign cmd = wr_cmd ? BUS_I.wdata[6:0] : 7'h00;

  // unit state
  logic       run_q;      // unit operating
  mode_e      mode_q;     // operating mode
  logic       ion_q;      // ionizer requested
  logic       err_q;      // error protection state
  logic       brk_q;      // ionizer breakdown
  logic [7:0] abn_q;      // recorded abnormality code
  logic [1:0] code_q;     // transmission code setting
  logic       fsel_q;     // selectable fault detection on
  logic       beep_en_q;  // reception beep on
  logic       heat_sb_q;  // forced heat standby
  logic       offt_exp;   // delay-off expiry this cycle
  logic       stop_ev;    // unit stop event
  logic       brk_set;    // breakdown set this cycle

  // writable control and off time; expiry clears the off timer
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= CTRL_RST;
      offt_q <= 18'h0;
    end else begin
      if (BUS_I.wr && BUS_I.addr == CTRL_OFS) ctrl_q <= BUS_I.wdata[9:0];
      else if (offt_exp) ctrl_q[K_OFFT] <= 1'b0;
      if (BUS_I.wr && BUS_I.addr == OFFT_OFS) offt_q <= BUS_I.wdata[17:0];
      else if (tick && ctrl_q[K_OFFT] && offt_q != 18'h0)
        offt_q <= offt_q - 18'h1;
    end
  end
  // expiry at the exact second the count lands on zero
  assign offt_exp = ctrl_q[K_OFFT] && tick && offt_q == 18'h1;

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 32'h0;
    end else if (BUS_I.rd) begin
      if (BUS_I.addr == CTRL_OFS) RDATA_O <= {22'h0, ctrl_q};
      else if (BUS_I.addr == OFFT_OFS) RDATA_O <= {14'h0, offt_q};
      else if (BUS_I.addr == STAT_OFS)
        RDATA_O <= {20'h0, heat_sb_q, beep_en_q, fsel_q, code_q,
                    brk_q, err_q, ion_q, COMP_EN_O, mode_q, run_q};
      else if (BUS_I.addr == ABN_OFS) RDATA_O <= {24'h0, abn_q};
      else RDATA_O <= 32'h0;
    end else begin
      RDATA_O <= 32'h0;
    end
  end

  // ************************************************************
  // auto switch: hold time in seconds, decoded at release
  // ************************************************************
  sw_e        sw_st_q;
  logic [4:0] hold_q;     // whole seconds held
  logic       sw_d_q;     // previous switch level
  logic       rel;        // release edge
  logic       f_auto, f_cool;
  assign rel = sw_d_q && !sw;

  // pure decode of a hold count into its band
  function automatic logic band(input logic [4:0] h,
                                input logic [4:0] lo,
                                input logic [4:0] hi);
    band = (h >= lo) && (h < hi);
  endfunction

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sw_d_q <= 1'b0;
      hold_q <= 5'h0;
    end else begin
      sw_d_q <= sw;
      if (sw && !sw_d_q) hold_q <= 5'h0;
      else if (sw && tick && hold_q != 5'h1F) hold_q <= hold_q + 5'h1;
    end
  end
  assign f_auto = rel && band(hold_q, 5'd0, HOLD_COOL);
  assign f_cool = rel && band(hold_q, HOLD_COOL, HOLD_HEAT);

  // switch sequencer: heat standby and code window wait for decrement
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sw_st_q   <= S_IDLE;
      code_q    <= 2'b00;
      fsel_q    <= 1'b1;
      beep_en_q <= 1'b1;
    end else begin
      case (sw_st_q)
        S_IDLE, S_HOLD, S_CODE, S_HEATSB: begin
          if (rel && band(hold_q, HOLD_HEAT, HOLD_CODE)) begin
            sw_st_q <= S_HEATSB;
          end else if (rel && band(hold_q, HOLD_CODE, HOLD_SEL)) begin
            sw_st_q <= S_CODE;
          end else if (rel) begin
            sw_st_q <= S_IDLE;
            if (band(hold_q, HOLD_SEL, HOLD_MAX)) begin
              if (ctrl_q[K_BEEPSEL]) beep_en_q <= ~beep_en_q;
              else fsel_q <= ~fsel_q;
            end
          end else if (cmd[C_DEC5] && sw_st_q == S_CODE) begin
            code_q  <= code_q + 2'b01;
            sw_st_q <= S_IDLE;
          end else if (cmd[C_DEC5] && sw_st_q == S_HEATSB) begin
            sw_st_q <= S_IDLE;
          end else if (cmd[C_OFF] || cmd[C_FOFF]) begin
            sw_st_q <= S_IDLE;
          end
        end
        default: sw_st_q <= S_IDLE;
      endcase
    end
  end
  always_comb heat_sb_q = (sw_st_q == S_HEATSB);

  // ************************************************************
  // unit run state and auto restart
  // ************************************************************
  logic [7:0] rst_cnt_q;  // restart seconds left
  logic       rst_pend_q; // restart pending
  logic [3:0] lfsr_q;     // pattern picker
  logic [3:0] pick;
  assign pick = (lfsr_q >= RST_PATS) ? lfsr_q - RST_PATS : lfsr_q;
  assign stop_ev = cmd[C_OFF] || cmd[C_FOFF] || offt_exp || brk_set;

  // free-running picker, varies with when supply comes back
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) lfsr_q <= 4'h1;
    else lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      run_q      <= 1'b0;
      mode_q     <= M_AUTO;
      rst_pend_q <= 1'b0;
      rst_cnt_q  <= 8'h0;
    end else begin
      if (stop_ev) begin
        run_q      <= 1'b0;
        rst_pend_q <= 1'b0;
      end else if (cmd[C_RESUME] && !ctrl_q[K_ONT] && !ctrl_q[K_OFFT]) begin
        run_q      <= 1'b1;
        rst_pend_q <= 1'b1;
        rst_cnt_q  <= RST_MIN_S + 8'(pick * RST_STEP_S);
      end else if (f_auto) begin
        run_q  <= 1'b1;
        mode_q <= M_AUTO;
      end else if (f_cool) begin
        run_q  <= 1'b1;
        mode_q <= M_COOL;
      end else if (cmd[C_DEC5] && heat_sb_q) begin
        run_q  <= 1'b1;
        mode_q <= M_HEAT;
      end else if (cmd[C_ON]) begin
        run_q <= 1'b1;
      end
      if (rst_pend_q && tick && !stop_ev) begin
        if (rst_cnt_q == 8'h1) rst_pend_q <= 1'b0;
        rst_cnt_q <= rst_cnt_q - 8'h1;
      end
    end
  end

  // ************************************************************
  // ionizer request, cycling and fault detection
  // ************************************************************
  logic [10:0] ph_q;   // seconds in current phase
  logic        ph_on_q; // on part of a low-feedback cycle
  logic [4:0]  cyc_q;  // consecutive low-feedback cycles
  logic [1:0]  hi_q;   // seconds of high feedback while off
  logic        ion_stop;
  assign ion_stop = cmd[C_OFF] || cmd[C_FOFF] || offt_exp || brk_set;

  // request flag; off events win, nothing survives an off
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ion_q <= 1'b0;
    end else if (ion_stop) begin
      ion_q <= 1'b0;
    end else if (cmd[C_ION]) begin
      ion_q <= ~ion_q;
    end
  end

  // error protection: set at the 24th cycle, left only by off/reset
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      err_q   <= 1'b0;
      cyc_q   <= 5'h0;
      ph_q    <= 11'h0;
      ph_on_q <= 1'b1;
    end else if (cmd[C_OFF] || cmd[C_FOFF]) begin
      err_q   <= 1'b0;
      cyc_q   <= 5'h0;
      ph_q    <= 11'h0;
      ph_on_q <= 1'b1;
    end else if (!ion_q || fb || err_q || !fsel_q) begin
      cyc_q   <= 5'h0;
      ph_q    <= 11'h0;
      ph_on_q <= 1'b1;
    end else if (tick) begin
      if (ph_on_q && ph_q == ION_ON_S - 11'h1) begin
        ph_q    <= 11'h0;
        ph_on_q <= 1'b0;
      end else if (!ph_on_q && ph_q == ION_OFF_S - 11'h1) begin
        ph_q    <= 11'h0;
        ph_on_q <= 1'b1;
        cyc_q   <= cyc_q + 5'h1;
        if (cyc_q == ION_CYC_MAX - 5'h1) err_q <= 1'b1;
      end else begin
        ph_q <= ph_q + 11'h1;
      end
    end
  end

  // breakdown: high feedback with ionizer off for 2s
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      brk_q <= 1'b0;
      hi_q  <= 2'h0;
      abn_q <= 8'h0;
    end else if (!fb) begin
      brk_q <= 1'b0;
      hi_q  <= 2'h0;
    end else if (!ION_O && tick && !brk_q) begin
      hi_q <= hi_q + 2'h1;
      if (hi_q == BRK_S - 2'h1) begin
        brk_q <= 1'b1;
        abn_q <= BRK_CODE;
      end
    end
  end
  assign brk_set = fb && !ION_O && tick && !brk_q && hi_q == BRK_S - 2'h1;

  // ************************************************************
  // outputs, all registered
  // ************************************************************
  logic any_cmd;
  assign any_cmd = |cmd[C_ANY:C_ON];
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      FAN_O       <= 1'b0;
      ION_O       <= 1'b0;
      COMP_EN_O   <= 1'b0;
      LED_RUN_O   <= 1'b0;
      LED_SCHED_O <= 1'b0;
      LED_ION_O   <= 1'b0;
      BEEP_O      <= 1'b0;
    end else begin
      FAN_O     <= run_q || ion_q;
      ION_O     <= ion_q && !err_q && (fb || !fsel_q || ph_on_q);
      COMP_EN_O <= run_q && !rst_pend_q;
      if (ctrl_q[K_HOT] || ctrl_q[K_DEICE] || ctrl_q[K_JUDGE]
          || ctrl_q[K_SAMPLE])
        LED_RUN_O <= blink_q;
      else
        LED_RUN_O <= run_q;
      if (ctrl_q[K_ABN] || brk_q) LED_SCHED_O <= blink_q;
      else LED_SCHED_O <= ctrl_q[K_ONT] || ctrl_q[K_OFFT];
      if (err_q || brk_q) LED_ION_O <= ion_q && blink_q;
      else LED_ION_O <= ion_q;
      BEEP_O <= (err_q && cmd[C_ION]) || (beep_en_q && any_cmd);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  off_expiry_a: assert property (offt_exp |=> !run_q)
    else $error("unit still running after off time");
  restart_delay_a: assert property ($rose(rst_pend_q) |->
      rst_cnt_q >= RST_MIN_S && rst_cnt_q <= 8'd232)
    else $error("restart delay out of range");
  timer_no_restart_a: assert property ((ctrl_q[K_ONT] || ctrl_q[K_OFFT])
      && !$past(SYS_RST_I) |-> !$rose(rst_pend_q))
    else $error("restart armed with timer set");
  cool_force_a: assert property (f_cool && !stop_ev && !cmd[C_RESUME]
      |=> run_q && mode_q == M_COOL)
    else $error("cooling not forced");
  ion_stop_a: assert property (ion_stop |=> !ion_q ##1 !ION_O)
    else $error("ionizer not stopped");
  err_off_a: assert property (err_q |=> !ION_O)
    else $error("ionizer on in error state");
  err_count_a: assert property ($rose(err_q) |-> $past(cyc_q) == 5'd23)
    else $error("error before 24 cycles");
  brk_stop_a: assert property (brk_set |=> !run_q && abn_q == BRK_CODE)
    else $error("breakdown did not stop unit");
  brk_clear_a: assert property (brk_q && !fb |=> !brk_q)
    else $error("breakdown not cleared");

  cover_restart_c: cover property ($fell(rst_pend_q) && run_q);
  cover_err_c: cover property ($rose(err_q));
  cover_brk_c: cover property ($rose(brk_q));
  cover_code_c: cover property (sw_st_q == S_CODE ##1 sw_st_q == S_IDLE);
endmodule
`default_nettype wire

// ### sim/ion_load_model.sv
/*
 file holds a behavioural model of the ionizer load and its feedback line.
 assumes the drive pin is sampled on the block clock; fault_i picks the load:
 0 healthy, 1 feedback stuck low (dead head), 2 feedback stuck high (breakdown).
*/
`timescale 1ns/1ps
`default_nettype none
module ion_load_model (
  // clock
  input  wire logic       clk_i,
  // drive from the block and fault selection from the bench
  input  wire logic       ion_i,
  input  wire logic [1:0] fault_i,
  // feedback back to the block
  output var  logic       fb_o
);
  // ************************************************************
  // feedback path
  // ************************************************************
  // a healthy head reports 5V one clock after drive; the lag mimics a real load
  initial fb_o = 1'b0;
  always @(posedge clk_i) begin
    case (fault_i)
      2'd1:    fb_o <= 1'b0; // dead head never answers
      2'd2:    fb_o <= 1'b1; // shorted sense line stays high
      default: fb_o <= ion_i;
    endcase
  end
endmodule
`default_nettype wire

// ### sim/aircon_house_bench.sv
/*
 file holds the self-checking bench of the housekeeping block.
 assumes the block runs with a four-cycle second tick and the ionizer model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module aircon_house_bench;
  import aircon_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  localparam int SC = 4;           // cycles per tick, keeps long holds short
  logic        mclk     = 1'b0;
  logic        sys_rst  = 1'b1;
  bus_s        bus      = '0;
  logic [31:0] rdata;
  logic        auto_sw  = 1'b0;    // panel switch, high while pressed
  logic        ion_fb;
  logic [1:0]  fault    = 2'd0;    // ionizer model fault choice
  logic        fan, ion, comp_en, led_run, led_sched, led_ion, beep;
  int          err_total = 0;
  int          samples_checked = 0;
  int          seed = 32'hd698;
  logic [31:0] s, s0;
  int          h, c, k;
  int          lo[5]   = '{1, 6, 9, 12, 17}; // holds kept off decode edges
  int          span[5] = '{3, 1, 1, 3, 3};
  initial begin
    forever #50 mclk = ~mclk;
  end
  aircon_house #(.SEC_CYCLES(SC)) aircon_house_inst (
    .MCLK_I(mclk), .SYS_RST_I(sys_rst), .BUS_I(bus), .RDATA_O(rdata),
    .AUTO_SW_I(auto_sw), .ION_FB_I(ion_fb), .FAN_O(fan), .ION_O(ion),
    .COMP_EN_O(comp_en), .LED_RUN_O(led_run), .LED_SCHED_O(led_sched),
    .LED_ION_O(led_ion), .BEEP_O(beep));
  ion_load_model ion_load_model_inst (
    .clk_i(mclk), .ion_i(ion), .fault_i(fault), .fb_o(ion_fb));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [2:0] mode_bits(mode_e m, logic run);
    return {m, run};
  endfunction
  // a restart delay is legal when it sits near one of the ten tick counts
  function automatic logic delay_ok(int cyc);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if ((cyc - (178 + 6 * i) * SC) <= SC + 3 && ((178 + 6 * i) * SC - cyc) <= SC + 3) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ticks(input int n);
    repeat (n * SC) @(posedge mclk);
  endtask
  // blinking shows both levels inside three ticks; steady shows one
  task automatic blink(input int w, input logic e, input string nm);
    int   n1;
    logic v;
    n1 = 0;
    repeat (3 * SC) begin
      @(posedge mclk);
      #1 v = (w == 0) ? led_run : (w == 1) ? led_sched : led_ion;
      if (v === 1'b1) n1++;
    end
    `CHK(nm, e, logic'(n1 > 0 && n1 < 3 * SC))
  endtask
  task automatic hold(input int n);
    @(posedge mclk);
    auto_sw <= 1'b1;
    ticks(n);
    auto_sw <= 1'b0;
    repeat (12) @(posedge mclk); // synchroniser plus decode
  endtask
  task automatic end_sim();
    $display("err_total %0d samples_checked %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    end_sim();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge mclk);
    `CHK("outputs in reset", 7'h00, {fan, ion, comp_en, led_run, led_sched, led_ion, beep})
    sys_rst <= 1'b0;
    // reset values, read-only status, unmapped place
    wr(STAT_OFS, 32'hFFFFFFFF);
    rd(STAT_OFS, s);
    `CHK("stat reset", 32'h00000606, s)
    rd(ABN_OFS, s);
    `CHK("abn reset", 32'h0, s)
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, s);
    `CHK("unmapped", 32'h0, s)
    // ionizer alone from standby, then stopped by the on/off button
    wr(CMD_OFS, 32'h4);
    #1 `CHK("beep on cmd", 1'b1, beep)
    repeat (8) @(posedge mclk);
    `CHK("ion only", 4'b1110, {fan, ion, led_ion, led_run})
    wr(CMD_OFS, 32'h2);
    repeat (8) @(posedge mclk);
    `CHK("ion off btn", 1'b0, ion)
    // ionizer with the unit running, ended by the delay-off expiry
    wr(CTRL_OFS, 32'h100);
    wr(OFFT_OFS, 32'h6);
    wr(CMD_OFS, 32'h1);
    wr(CMD_OFS, 32'h4);
    repeat (8) @(posedge mclk);
    `CHK("ion run", 3'b111, {ion, led_ion, led_run})
    rd(STAT_OFS, s);
    `CHK("run before expiry", 1'b1, s[0])
    ticks(4);
    rd(STAT_OFS, s);
    `CHK("run after expiry", 1'b0, s[0])
    `CHK("ion timer off", 1'b0, ion)
    wr(CTRL_OFS, 32'h0);
    wr(CMD_OFS, 32'h1);
    repeat (8) @(posedge mclk);
    rd(STAT_OFS, s);
    `CHK("ion not kept", 2'b00, {ion, s[4]})
    // dead head: ten ticks on, then the long off phase
    fault <= 2'd1;
    wr(CMD_OFS, 32'h4);
    ticks(2);
    `CHK("low fb on phase", 1'b1, ion)
    ticks(10);
    rd(STAT_OFS, s);
    `CHK("low fb off phase", 3'b010, {ion, s[4], s[5]})
    fault <= 2'd0;
    wr(CMD_OFS, 32'h2);
    // blinking run and schedule indicators
    wr(CMD_OFS, 32'h1);
    for (k = K_HOT; k <= K_SAMPLE; k++) begin
      wr(CTRL_OFS, 32'h1 << k);
      blink(0, 1'b1, "run blink");
    end
    wr(CTRL_OFS, 32'h1 << K_ABN);
    blink(1, 1'b1, "sched blink");
    wr(CTRL_OFS, 32'h0);
    blink(0, 1'b0, "run steady");
    blink(1, 1'b0, "sched steady");
    // breakdown: feedback high with drive low while running
    fault <= 2'd2;
    ticks(1);
    rd(STAT_OFS, s);
    `CHK("no early breakdown", 1'b0, s[6])
    ticks(3);
    rd(STAT_OFS, s);
    `CHK("breakdown", 2'b10, {s[6], s[0]})
    rd(ABN_OFS, s);
    `CHK("abn code", 32'h00000026, s)
    blink(1, 1'b1, "breakdown sched");
    fault <= 2'd0;
    repeat (8) @(posedge mclk);
    rd(STAT_OFS, s);
    `CHK("breakdown clear", 1'b0, s[6])
    blink(1, 1'b0, "sched cleared");
    // auto restart after supply loss, then barred by a timer setting
    wr(CMD_OFS, 32'h10);
    rd(STAT_OFS, s);
    `CHK("resume run", 1'b1, s[0])
    c = 0;
    while (comp_en !== 1'b1 && c < 1200) begin
      @(posedge mclk);
      c++;
    end
    `CHK("restart delay", 1'b1, delay_ok(c))
    wr(CMD_OFS, 32'h2);
    wr(CTRL_OFS, 32'h1 << K_ONT);
    wr(CMD_OFS, 32'h10);
    repeat (20) @(posedge mclk);
    rd(STAT_OFS, s);
    `CHK("no restart timer", 2'b00, {s[0], comp_en})
    wr(CTRL_OFS, 32'h0);
    // auto switch hold times, each drawn inside its window
    for (k = 0; k < 5; k++) begin
      wr(CMD_OFS, 32'h2);
      rd(STAT_OFS, s0);
      h = lo[k] + (($random(seed) & 32'h7FFF) % span[k]);
      hold(h);
      rd(STAT_OFS, s);
      case (k)
        0: `CHK("auto hold", mode_bits(M_AUTO, 1'b1), s[2:0])
        1: `CHK("cool hold", mode_bits(M_COOL, 1'b1), s[2:0])
        2: begin
          `CHK("heat standby", 1'b1, s[11])
          wr(CMD_OFS, 32'h8);
          rd(STAT_OFS, s);
          `CHK("heat start", mode_bits(M_HEAT, 1'b1), s[2:0])
        end
        3: begin
          wr(CMD_OFS, 32'h8);
          rd(STAT_OFS, s);
          `CHK("code step", s0[8:7] + 2'd1, s[8:7])
        end
        default: `CHK("fsel toggle", ~s0[9], s[9])
      endcase
    end
    end_sim();
  end
endmodule
`default_nettype wire
